// *** hdl/sfa_defines.svh ***
// Constants for the serial flash address-mode and read front end.
// Assumes inclusion by its bare name from the package and the design.
`ifndef SFA_DEFINES_SVH
`define SFA_DEFINES_SVH

// ****************************************************************
// Opcodes
// ****************************************************************
`define SFA_OP_EXT_FETCH    8'hc8
`define SFA_OP_EXT_STORE    8'hc5
`define SFA_OP_ENTER_4B     8'hb7
`define SFA_OP_EXIT_4B      8'he9
`define SFA_OP_READ         8'h03
`define SFA_OP_READ_4B      8'h13
`define SFA_OP_FAST_READ    8'h0b
`define SFA_OP_DR_FAST_READ 8'h0d

// ****************************************************************
// Field layout, widths and reset values
// ****************************************************************
`define SFA_UAB_HI          1
`define SFA_UAB_LO          0
`define SFA_UAB_RESET       8'h00
`define SFA_ARRAY_AW        26
`define SFA_CMD_BITS        6'h08
`define SFA_ADDR3_BITS      6'h18
`define SFA_ADDR4_BITS      6'h20
`define SFA_REG_BITS        6'h08

// ****************************************************************
// Dummy clock counts
// ****************************************************************
`define SFA_DUMMY_SPI_FAST  4'h8
`define SFA_DUMMY_SPI_DR    4'h6
`define SFA_DUMMY_Q_DR      4'h8
`define SFA_DUMMY_Q_DR_ALT  4'ha
`define SFA_DUMMY_P00       4'ha
`define SFA_DUMMY_P01       4'h4
`define SFA_DUMMY_P10       4'h6
`define SFA_DUMMY_P11       4'h8

`endif

// *** hdl/sfa_pkg.sv ***
// Types shared by the serial flash read front end.
// Assumes the defines header sits beside it on the include path.
`include "sfa_defines.svh"

package sfa_pkg;

	// Phase of the current chip-select frame.
	typedef enum logic [2:0] {
		SFA_CMD,
		SFA_ADDR,
		SFA_DUMMY,
		SFA_DATA,
		SFA_REGOUT,
		SFA_REGIN,
		SFA_HOLD,
		SFA_IGNORE
	} sfa_phase_e;

	typedef logic [`SFA_ARRAY_AW-1:0] sfa_aaddr_t;

endpackage : sfa_pkg

// *** hdl/sfa_flash_front.sv ***
// Command front end of a serial NOR flash: address modes and basic reads.
// Assumes pins arrive asynchronously, core_clk runs well above the link
// clock, and the array answers a request within a few core cycles.
`timescale 1ns/1ps
`include "sfa_defines.svh"

// How it works
// - In 3-byte mode, except for 13h, address bits 31..24 come from the upper address byte.
// - Opcode C8h sampled on rising edges; byte shifted out on falling, MSB first.
// - In 4-byte mode the upper address byte is not used for addressing.
// - Register keeps bits 1..0 only; upper bits read zero; resets to zero.
// - The two upper bits pick one of four 16 MB segments over two dies.
// - Opcode C5h plus one byte writes the register only with latch set.
// - Power up and any reset clear the upper address byte.
// - In 4-byte mode an address with bits 31..24 overwrites the register.
// - Opcode B7h enters 4-byte mode at chip select rise.
// - Opcode E9h returns to 3-byte mode at chip select rise.
// - Read 03h takes 24 or 32 address bits by mode; data MSB first.
// - Address advances each byte; streaming lasts until chip select rises.
// - Read opcodes while busy are ignored without other effect.
// - Read 13h always takes a 32-bit address.
// - Fast read 0Bh; the address counter wraps to zero past the top.
// - Quad fast read dummy count follows the read parameter field.
// - Double rate read 0Dh uses both edges; six dummy clocks in SPI.
// - Double rate read also runs in quad mode; ten dummies when select set.
// - Address width flag reads 0 in 3-byte mode, 1 in 4-byte mode.
// - Power-up select chooses the address mode after reset.
// - Dummy select defaults to 0; quad double rate uses 8, else 10.
module sfa_flash_front (
	// Clock and reset
	input  wire logic               core_clk,
	input  wire logic               sys_rst,
	input  wire logic               soft_rst,
	// Flash pins
	input  wire logic               sclk_pin,
	input  wire logic               cs_n_pin,
	input  wire logic [3:0]         io_in,
	output logic      [3:0]         io_out,
	output logic      [3:0]         io_oe_n,
	// Configuration and status from the rest of the device
	input  wire logic               busy,
	input  wire logic               write_enable_latch,
	input  wire logic               quad_command_mode,
	input  wire logic [1:0]         read_param,
	input  wire logic               dummy_count_select,
	input  wire logic               power_up_addr_width_select,
	// Address mode state
	output logic                    current_addr_width_flag,
	output logic      [7:0]         upper_addr_byte,
	output logic                    ext_store_done,
	// Array read port
	output logic                    arr_req,
	output sfa_pkg::sfa_aaddr_t     arr_addr,
	input  wire logic               arr_rsp_valid,
	input  wire logic [7:0]         arr_rsp_data,
	output logic                    arr_rsp_ready
);
	import sfa_pkg::*;

	// ****************************************************************
	// Functions
	// ****************************************************************

	// Shifts one or four lanes into the low end of a word.
	function automatic logic [31:0] shift_in(input logic [31:0] w,
		input logic [3:0] d, input logic q);
		shift_in = q ? {w[27:0], d} : {w[30:0], d[0]};
	endfunction : shift_in

	// Maps the quad read parameter field to dummy clocks.
	function automatic logic [3:0] param_dummy(input logic [1:0] p);
		case (p)
			2'h0:    param_dummy = `SFA_DUMMY_P00;
			2'h1:    param_dummy = `SFA_DUMMY_P01;
			2'h2:    param_dummy = `SFA_DUMMY_P10;
			default: param_dummy = `SFA_DUMMY_P11;
		endcase
	endfunction : param_dummy

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic       sclk_s1, sclk_s2, sclk_s3;
	logic       cs_s1, cs_s2, cs_s3;
	logic [3:0] io_s1, io_s2;

	// Two flops per pin; the third stage only feeds edge detection.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sclk_s1 <= 1'b0;
			sclk_s2 <= 1'b0;
			sclk_s3 <= 1'b0;
			cs_s1   <= 1'b1;
			cs_s2   <= 1'b1;
			cs_s3   <= 1'b1;
			io_s1   <= 4'h0;
			io_s2   <= 4'h0;
		end else begin
			sclk_s1 <= sclk_pin;
			sclk_s2 <= sclk_s1;
			sclk_s3 <= sclk_s2;
			cs_s1   <= cs_n_pin;
			cs_s2   <= cs_s1;
			cs_s3   <= cs_s2;
			io_s1   <= io_in;
			io_s2   <= io_s1;
		end
	end

	// ****************************************************************
	// Frame state
	// ****************************************************************
	sfa_phase_e  phase;
	logic [7:0]  opc;
	logic [5:0]  cnt;
	logic [3:0]  dcnt;
	logic [31:0] sh;
	logic        dr_cmd;
	logic        a32;
	logic        wel_seen;
	logic [7:0]  osh;
	logic [3:0]  ocnt;
	sfa_aaddr_t  fa;
	logic        rd_on;

	// Edges of the sampled link clock and chip select.
	wire        sck_rise = sclk_s2 & ~sclk_s3;
	wire        sck_fall = ~sclk_s2 & sclk_s3;
	wire        cs_end   = cs_s2 & ~cs_s3;
	wire        in_frame = ~cs_s2;
	wire        quad     = quad_command_mode;
	wire [5:0]  lanes    = quad ? 6'h04 : 6'h01;
	wire [3:0]  olanes   = quad ? 4'h4 : 4'h1;

	// Address bits sample on both edges only for double rate reads.
	wire        samp     = in_frame & (sck_rise | (dr_cmd & phase == SFA_ADDR & sck_fall));
	wire [31:0] sh_next  = shift_in(sh, io_s2, quad);
	wire [5:0]  cnt_next = cnt + lanes;
	wire [7:0]  cmd_byte = sh_next[7:0];

	// Opcode classification.
	wire op_rd   = cmd_byte == `SFA_OP_READ;
	wire op_rd4  = cmd_byte == `SFA_OP_READ_4B;
	wire op_fr   = cmd_byte == `SFA_OP_FAST_READ;
	wire op_dr   = cmd_byte == `SFA_OP_DR_FAST_READ;
	wire op_read = op_rd | op_rd4 | op_fr | op_dr;
	wire op_mode = (cmd_byte == `SFA_OP_ENTER_4B) | (cmd_byte == `SFA_OP_EXIT_4B);

	// Address length: 13h always 32 bits, others by current mode.
	wire       want32 = op_rd4 | current_addr_width_flag;
	wire [5:0] alen   = a32 ? `SFA_ADDR4_BITS : `SFA_ADDR3_BITS;

	// Dummy clocks per read type and line mode.
	wire [3:0] dum_fr = quad ? param_dummy(read_param) : `SFA_DUMMY_SPI_FAST;
	wire [3:0] dum_dq = dummy_count_select ? `SFA_DUMMY_Q_DR_ALT : `SFA_DUMMY_Q_DR;
	wire [3:0] dum_dr = quad ? dum_dq : `SFA_DUMMY_SPI_DR;
	wire [3:0] dum_op = (opc == `SFA_OP_FAST_READ) ? dum_fr :
	                    (opc == `SFA_OP_DR_FAST_READ) ? dum_dr : 4'h0;

	// Full array address: the upper byte stands in for bits 31..24 of a 24-bit address.
	wire [31:0] full_addr = a32 ? sh_next : {upper_addr_byte, sh_next[23:0]};
	wire        addr_done = phase == SFA_ADDR & samp & cnt_next == alen;

	// ****************************************************************
	// Two-entry data buffer
	// ****************************************************************
	logic [7:0] buf_mem [0:1];
	logic       wr_ptr, rd_ptr;
	logic [1:0] buf_cnt;
	logic [1:0] pending;
	logic       discard;

	wire drv      = in_frame & ((phase == SFA_DATA & (sck_fall | (dr_cmd & sck_rise))) |
	                (phase == SFA_REGOUT & sck_fall));
	wire need     = drv & ocnt == 4'h0;
	wire push     = arr_rsp_valid & arr_rsp_ready & ~discard;
	wire pop      = need & phase == SFA_DATA & buf_cnt != 2'h0;
	wire rsp_take = arr_rsp_valid & arr_rsp_ready;
	wire [1:0] next_buf_cnt = in_frame ? buf_cnt + {1'b0, push} - {1'b0, pop} : 2'h0;
	wire [1:0] next_pending = pending + {1'b0, arr_req} - {1'b0, rsp_take};
	wire [2:0] credit = {1'b0, next_buf_cnt} + {1'b0, next_pending};
	wire       next_req = (rd_on | addr_done) & in_frame & ~discard & credit < 3'h2;
	wire [`SFA_ARRAY_AW-1:0] req_addr = addr_done ? full_addr[`SFA_ARRAY_AW-1:0] : fa; // Early first fetch.

	// Buffer storage; a stalled shifter leaves words here, so none is lost.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wr_ptr        <= 1'b0;
			rd_ptr        <= 1'b0;
			buf_cnt       <= 2'h0;
			arr_rsp_ready <= 1'b0;
		end else begin
			if (push)
				buf_mem[wr_ptr] <= arr_rsp_data;
			wr_ptr        <= in_frame ? wr_ptr ^ push : 1'b0;
			rd_ptr        <= in_frame ? rd_ptr ^ pop : 1'b0;
			buf_cnt       <= next_buf_cnt;
			arr_rsp_ready <= next_buf_cnt != 2'h2;
		end
	end

	// Requests stay within two credits; answers from a dead frame are dropped.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pending  <= 2'h0;
			discard  <= 1'b0;
			arr_req  <= 1'b0;
			arr_addr <= '0;
			fa       <= '0;
		end else begin
			pending  <= next_pending;
			discard  <= cs_end ? next_pending != 2'h0 : discard & next_pending != 2'h0;
			arr_req  <= next_req;
			if (next_req) begin
				arr_addr <= req_addr;
				fa       <= req_addr + 1'b1;
			end else if (addr_done)
				fa <= req_addr;
		end
	end

	// ****************************************************************
	// Command sequencer
	// ****************************************************************

	// Walks each frame through opcode, address, dummy and data phases.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			phase    <= SFA_CMD;
			opc      <= 8'h00;
			cnt      <= 6'h00;
			dcnt     <= 4'h0;
			sh       <= 32'h0;
			dr_cmd   <= 1'b0;
			a32      <= 1'b0;
			wel_seen <= 1'b0;
			rd_on    <= 1'b0;
		end else if (!in_frame) begin
			phase  <= SFA_CMD;
			cnt    <= 6'h00;
			dr_cmd <= 1'b0;
			rd_on  <= 1'b0;
		end else if (phase == SFA_DUMMY) begin
			if (sck_rise) begin
				dcnt <= dcnt - 4'h1;
				if (dcnt == 4'h1)
					phase <= SFA_DATA;
			end
		end else if (samp) begin
			sh  <= sh_next;
			cnt <= cnt_next;
			case (phase)
				SFA_CMD: begin
					if (cnt_next == `SFA_CMD_BITS) begin
						opc      <= cmd_byte;
						cnt      <= 6'h00;
						wel_seen <= write_enable_latch;
						a32      <= want32;
						if (op_read & busy)
							phase <= SFA_IGNORE;
						else if (op_read) begin
							phase  <= SFA_ADDR;
							dr_cmd <= op_dr;
						end else if (cmd_byte == `SFA_OP_EXT_FETCH)
							phase <= SFA_REGOUT;
						else if (cmd_byte == `SFA_OP_EXT_STORE)
							phase <= SFA_REGIN;
						else if (op_mode)
							phase <= SFA_HOLD;
						else
							phase <= SFA_IGNORE;
					end
				end
				SFA_ADDR: begin
					if (addr_done) begin
						rd_on <= 1'b1;
						dcnt  <= dum_op;
						phase <= (dum_op == 4'h0) ? SFA_DATA : SFA_DUMMY;
					end
				end
				SFA_HOLD: phase <= SFA_IGNORE;
				SFA_REGIN: begin
					if (cnt_next > `SFA_REG_BITS)
						phase <= SFA_IGNORE;
				end
				default: cnt <= cnt;
			endcase
		end
	end

	// ****************************************************************
	// Address mode and upper address byte
	// ****************************************************************

	// Store only on a clean eight-bit boundary with the latch seen set.
	wire store_ok = cs_end & phase == SFA_REGIN & cnt == `SFA_REG_BITS & wel_seen;
	wire mode_cmd = cs_end & phase == SFA_HOLD;

	// Mode and register updates; the power-up select is caught while reset is held.
	always_ff @(posedge core_clk) begin
		if (sys_rst | soft_rst) begin
			current_addr_width_flag <= power_up_addr_width_select;
			upper_addr_byte         <= `SFA_UAB_RESET;
			ext_store_done          <= 1'b0;
		end else begin
			ext_store_done <= store_ok;
			if (mode_cmd)
				current_addr_width_flag <= opc == `SFA_OP_ENTER_4B;
			if (store_ok)
				upper_addr_byte <= {6'h00, sh[`SFA_UAB_HI:`SFA_UAB_LO]};
			else if (addr_done & current_addr_width_flag)
				upper_addr_byte <= {6'h00, sh_next[25:24]};
		end
	end

	// ****************************************************************
	// Output shifter
	// ****************************************************************

	// An empty buffer yields zeros; the array must keep ahead of the link.
	wire [7:0] src_byte = (phase == SFA_REGOUT) ? upper_addr_byte :
	                      (buf_cnt != 2'h0) ? buf_mem[rd_ptr] : 8'h00;
	wire [7:0] cur_byte = need ? src_byte : osh;
	wire [3:0] o_val    = quad ? cur_byte[7:4] : {2'b00, cur_byte[7], 1'b0};
	wire [3:0] o_en_n   = quad ? 4'h0 : 4'hd;

	// Drives MSB first, one or four lanes per drive edge.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			io_out  <= 4'h0;
			io_oe_n <= 4'hf;
			osh     <= 8'h00;
			ocnt    <= 4'h0;
		end else if (!in_frame) begin
			io_oe_n <= 4'hf;
			ocnt    <= 4'h0;
		end else if (drv) begin
			io_out  <= o_val;
			io_oe_n <= o_en_n;
			osh     <= quad ? {cur_byte[3:0], 4'h0} : {cur_byte[6:0], 1'b0};
			ocnt    <= need ? 4'h8 - olanes : ocnt - olanes;
		end
	end

endmodule : sfa_flash_front

// *** sim/sfa_front_props.sv ***
// Concurrent checks on the ports of the flash front end.
// Assumes it is bound into sfa_flash_front; one clock domain.
`timescale 1ns/1ps
// ****************************************
// Checker
// ****************************************
module sfa_front_props (
	// Clock and resets
	input wire logic       core_clk,
	input wire logic       sys_rst,
	input wire logic       soft_rst,
	// Observed ports
	input wire logic       cs_n_pin,
	input wire logic       power_up_addr_width_select,
	input wire logic [3:0] io_oe_n,
	input wire logic       current_addr_width_flag,
	input wire logic [7:0] upper_addr_byte,
	input wire logic       ext_store_done,
	input wire logic       arr_req
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// A frame is surely over after a full link period with chip select high.
	sequence cs_idle; cs_n_pin [*8]; endsequence
	sequence soft_pulse; soft_rst ##1 !soft_rst; endsequence
	// The register changes only through a store, a 4-byte address or a reset.
	reserved_zero_a: assert property (upper_addr_byte[7:2] == 6'h00)
		else $error("upper byte reserved bits set");
	soft_clear_a: assert property (soft_pulse |-> upper_addr_byte == 8'h00)
		else $error("upper byte not cleared by soft reset");
	soft_mode_a: assert property (soft_pulse |-> current_addr_width_flag == power_up_addr_width_select)
		else $error("mode not reloaded by soft reset");
	uab_cause_a: assert property ($changed(upper_addr_byte) |-> ext_store_done || $past(ext_store_done)
		|| current_addr_width_flag || $past(current_addr_width_flag) || $past(soft_rst))
		else $error("upper byte changed without cause");
	store_pulse_a: assert property (ext_store_done |=> !ext_store_done)
		else $error("store pulse longer than one cycle");
	// Mode switches only land once the frame has closed.
	mode_at_cs_a: assert property ($changed(current_addr_width_flag) |-> cs_n_pin || $past(soft_rst))
		else $error("mode changed inside a frame");
	idle_quiet_a: assert property (cs_idle |-> io_oe_n == 4'hf && !arr_req)
		else $error("output or fetch while deselected");
	oe_legal_a: assert property (io_oe_n inside {4'hf, 4'hd, 4'h0})
		else $error("illegal lane enable pattern");
endmodule : sfa_front_props
// Attach the checker to every front end instance.
bind sfa_flash_front sfa_front_props u_props (.core_clk(core_clk), .sys_rst(sys_rst), .soft_rst(soft_rst),
	.cs_n_pin(cs_n_pin), .power_up_addr_width_select(power_up_addr_width_select), .io_oe_n(io_oe_n),
	.current_addr_width_flag(current_addr_width_flag), .upper_addr_byte(upper_addr_byte),
	.ext_store_done(ext_store_done), .arr_req(arr_req));

// *** sim/sfa_host_model.sv ***
// Host controller model that clocks the flash link in mode 0, single-line or quad.
// Assumes the core clock paces it; one link period is eight core cycles.
`timescale 1ns/1ps
// ****************************************
// Link host model
// ****************************************
module sfa_host_model (
	// Pacing clock
	input  wire logic       core_clk,
	// Link pins
	output logic            sclk_pin,
	output logic            cs_n_pin,
	output logic [3:0]      io_in,
	input  wire logic [3:0] io_out,
	input  wire logic [3:0] io_oe_n
);
	// Idle link: clock parked low, device deselected.
	initial begin
		sclk_pin = 1'b0;
		cs_n_pin = 1'b1;
		io_in = 4'h5;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(posedge core_clk);
	endtask : wait_clk
	// Data is set while the clock is low and the answer read just before the rise.
	// A lane the device does not drive reads inverted, so a stale level never passes.
	task automatic bit_xfer(input logic tx, output logic rx);
		io_in[0] <= tx;
		wait_clk(5);
		rx = io_out[1] ^ io_oe_n[1];
		sclk_pin <= 1'b1;
		wait_clk(3);
		sclk_pin <= 1'b0;
	endtask : bit_xfer
	// One quad clock: a nibble out on all four lanes, a nibble back.
	task automatic nib_xfer(input logic [3:0] tx, output logic [3:0] rx);
		io_in <= tx;
		wait_clk(5);
		rx = io_out ^ io_oe_n;
		sclk_pin <= 1'b1;
		wait_clk(3);
		sclk_pin <= 1'b0;
	endtask : nib_xfer
	// MSB first; when not driving, the line toggles so no stale level lingers.
	task automatic byte_xfer(input logic [7:0] tx, input logic drv, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) bit_xfer(drv ? tx[i] : ~io_in[0], rx[i]);
	endtask : byte_xfer
	task automatic cs_low();
		cs_n_pin <= 1'b0;
		wait_clk(4);
	endtask : cs_low
	// The gap after a frame spans more than two link periods.
	task automatic cs_high();
		wait_clk(4);
		cs_n_pin <= 1'b1;
		io_in <= ~io_in;
		wait_clk(20);
	endtask : cs_high
endmodule : sfa_host_model

// *** sim/sfa_flash_front_bench.sv ***
// Self-checking bench for the flash front end.
// Assumes the host model drives the pins and a one-cycle array answers here.
`timescale 1ns/1ps
// ****************************************
// Bench
// ****************************************
module sfa_flash_front_bench;
	import sfa_pkg::*;
	// Design pins and bookkeeping.
	logic       core_clk, sys_rst = 1'b1, soft_rst = 1'b0, busy = 1'b0, write_enable_latch = 1'b0;
	logic       power_up_addr_width_select = 1'b0, arr_rsp_valid = 1'b0, arr_req, ext_store_done;
	logic       sclk_pin, cs_n_pin, current_addr_width_flag, arr_rsp_ready;
	logic       quad_command_mode = 1'b0;
	logic [1:0] read_param = 2'b00;
	logic [3:0] io_in, io_out, io_oe_n;
	logic [7:0] arr_rsp_data = 8'h00, upper_addr_byte, got[$];
	sfa_aaddr_t arr_addr, reqs[$];
	int         n_errors = 0;
	int         checks_done = 0;
	// Core clock.
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	sfa_host_model host (.core_clk(core_clk), .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin), .io_in(io_in),
		.io_out(io_out), .io_oe_n(io_oe_n));
	sfa_flash_front dut (.core_clk(core_clk), .sys_rst(sys_rst), .soft_rst(soft_rst), .sclk_pin(sclk_pin),
		.cs_n_pin(cs_n_pin), .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n), .busy(busy),
		.write_enable_latch(write_enable_latch), .quad_command_mode(quad_command_mode), .read_param(read_param),
		.dummy_count_select(1'b0), .power_up_addr_width_select(power_up_addr_width_select),
		.current_addr_width_flag(current_addr_width_flag), .upper_addr_byte(upper_addr_byte),
		.ext_store_done(ext_store_done), .arr_req(arr_req), .arr_addr(arr_addr),
		.arr_rsp_valid(arr_rsp_valid), .arr_rsp_data(arr_rsp_data), .arr_rsp_ready(arr_rsp_ready));
	// The array answers one cycle after each request; every asked address is logged.
	always @(posedge core_clk) begin
		arr_rsp_valid <= arr_req === 1'b1;
		arr_rsp_data <= arr_addr[7:0] ^ 8'ha5;
		if (arr_req === 1'b1) reqs.push_back(arr_addr);
	end
	task automatic check_byte(input logic [7:0] g, input logic [7:0] e);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %0t byte got %h exp %h", $time, g, e);
		end
	endtask : check_byte
	task automatic check_addr(input sfa_aaddr_t g, input sfa_aaddr_t e);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %0t address got %h exp %h", $time, g, e);
		end
	endtask : check_addr
	// One read frame: opcode, address bytes, dummy bits, then nb bytes collected.
	task automatic rd(input logic [7:0] op, input logic [31:0] a, input int na, input int nd, input int nb);
		logic [7:0] rx;
		reqs.delete();
		got.delete();
		host.cs_low();
		host.byte_xfer(op, 1'b1, rx);
		for (int i = na - 1; i >= 0; i--) host.byte_xfer(a[8*i+:8], 1'b1, rx);
		for (int i = 0; i < nd; i++) host.bit_xfer(~io_in[0], rx[0]);
		for (int i = 0; i < nb; i++) begin
			host.byte_xfer(8'h00, 1'b0, rx);
			got.push_back(rx);
		end
		host.cs_high();
	endtask : rd
	// One quad fast read: two opcode nibbles, six address nibbles, nd dummy clocks, nb bytes.
	task automatic qrd(input logic [23:0] a, input int nd, input int nb);
		logic [3:0] rx;
		logic [3:0] hi;
		reqs.delete();
		got.delete();
		host.cs_low();
		host.nib_xfer(4'h0, rx);
		host.nib_xfer(4'hb, rx);
		for (int i = 5; i >= 0; i--) host.nib_xfer(a[4*i+:4], rx);
		for (int i = 0; i < nd; i++) host.nib_xfer(4'h0, rx);
		for (int i = 0; i < nb; i++) begin
			host.nib_xfer(4'h0, hi);
			host.nib_xfer(4'h0, rx);
			got.push_back({hi, rx});
		end
		host.cs_high();
	endtask : qrd
	// Short frame: mode 0 opcode only, 1 writes a byte, 2 reads one back.
	task automatic frame(input logic [7:0] op, input logic [7:0] d, input int m, output logic [7:0] rx);
		host.cs_low();
		host.byte_xfer(op, 1'b1, rx);
		if (m > 0) host.byte_xfer(d, m == 1, rx);
		host.cs_high();
	endtask : frame
	// Addresses must step by one, wrapping at the array top.
	task automatic expect_read(input sfa_aaddr_t base, input int nb);
		for (int k = 0; k < nb; k++) begin
			check_addr(reqs[k], base + sfa_aaddr_t'(k));
			check_byte(got[k], 8'(base + sfa_aaddr_t'(k)) ^ 8'ha5);
		end
	endtask : expect_read
	task automatic t_store();
		logic [7:0] rx;
		check_byte({7'h00, current_addr_width_flag}, 8'h00);
		check_byte(upper_addr_byte, 8'h00);
		check_byte({7'h00, arr_rsp_ready}, 8'h01);
		frame(8'hc5, 8'hfe, 1, rx);
		check_byte(upper_addr_byte, 8'h00);
		write_enable_latch <= 1'b1;
		frame(8'hc5, 8'hff, 1, rx);
		check_byte(upper_addr_byte, 8'h03);
		write_enable_latch <= 1'b0;
		frame(8'hc8, 8'h00, 2, rx);
		check_byte(rx, 8'h03);
		$display("t_store done");
	endtask : t_store
	task automatic t_read3();
		rd(8'h03, 32'h00123456, 3, 0, 2);
		expect_read({2'b11, 24'h123456}, 2);
		rd(8'h0b, 32'h00ffffff, 3, 8, 2);
		expect_read(26'h3ffffff, 2);
		busy <= 1'b1;
		rd(8'h03, 32'h00000100, 3, 0, 1);
		check_byte({7'h00, reqs.size() != 0}, 8'h00);
		busy <= 1'b0;
		$display("t_read3 done");
	endtask : t_read3
	task automatic t_four();
		logic [7:0] rx;
		frame(8'hb7, 8'h00, 0, rx);
		check_byte({7'h00, current_addr_width_flag}, 8'h01);
		rd(8'h03, 32'h01000020, 4, 0, 1);
		expect_read(26'h1000020, 1);
		check_byte(upper_addr_byte, 8'h01);
		frame(8'he9, 8'h00, 0, rx);
		check_byte({7'h00, current_addr_width_flag}, 8'h00);
		frame(8'hc8, 8'h00, 2, rx);
		check_byte(rx, 8'h01);
		rd(8'h13, 32'h02000040, 4, 0, 1);
		expect_read(26'h2000040, 1);
		rd(8'h03, 32'h00000008, 3, 0, 1);
		expect_read({2'b01, 24'h000008}, 1);
		$display("t_four done");
	endtask : t_four
	// Quad fast read with two read parameter settings; a wrong dummy count shifts the data.
	task automatic t_quad();
		quad_command_mode <= 1'b1;
		read_param <= 2'b01;
		qrd(24'h000200, 4, 2);
		expect_read({2'b01, 24'h000200}, 2);
		read_param <= 2'b00;
		qrd(24'h000300, 10, 2);
		expect_read({2'b01, 24'h000300}, 2);
		quad_command_mode <= 1'b0;
		$display("t_quad done");
	endtask : t_quad
	task automatic t_soft();
		power_up_addr_width_select <= 1'b1;
		soft_rst <= 1'b1;
		@(posedge core_clk) soft_rst <= 1'b0;
		repeat (3) @(posedge core_clk);
		check_byte({7'h00, current_addr_width_flag}, 8'h01);
		check_byte(upper_addr_byte, 8'h00);
		$display("t_soft done");
	endtask : t_soft
	task automatic test_done();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : test_done
	// Reset for six cycles, then run the scenarios.
	initial begin
		repeat (6) @(posedge core_clk);
		sys_rst <= 1'b0;
		repeat (6) @(posedge core_clk);
		t_store();
		t_read3();
		t_four();
		t_quad();
		t_soft();
		test_done();
	end
	// Watchdog: the run needs about 29 us, so 500 us means a hang.
	initial begin
		#500000;
		n_errors++;
		$display("ERROR %0t watchdog expired", $time);
		test_done();
	end
endmodule : sfa_flash_front_bench
